// File: include/ebpa_consts.svh
// register offsets, field positions, reset values and counts of the bus pin logic
`ifndef EBPA_CONSTS_SVH
`define EBPA_CONSTS_SVH
// ----------------------------------------
// register byte offsets (low address byte)
// ----------------------------------------
`define EBPA_CTRL_OFS 8'h00
`define EBPA_BANKPAR_OFS 8'h04
`define EBPA_IRQSEL_OFS 8'h08
`define EBPA_STATUS_OFS 8'h0c
// ----------------------------------------
// control fields
// ----------------------------------------
`define EBPA_CTRL_EXTARB 0
`define EBPA_CTRL_OTHERPAR 1
`define EBPA_CTRL_EVENPAR 2
`define EBPA_CTRL_PRIO_LO 4
`define EBPA_CTRL_RESET 32'h0000_0000
`define EBPA_BANKPAR_RESET 8'h00
// ----------------------------------------
// interrupt select fields
// ----------------------------------------
`define EBPA_IRQSEL_CR 4
`define EBPA_IRQSEL_KR 5
`define EBPA_IRQSEL_FRZ 6
`define EBPA_IRQSEL_RESET 7'h00
// ----------------------------------------
// status fields
// ----------------------------------------
`define EBPA_ST_OWNED 0
`define EBPA_ST_PARERR 1
`define EBPA_ST_TIMEOUT 2
`define EBPA_ST_LANE_LO 4
`define EBPA_ST_STATE_LO 8
// ----------------------------------------
// timing
// ----------------------------------------
`define EBPA_MON_CYCLES 256
`endif

// File: include/ebpa_pkg.sv
// types shared by the bus pin logic modules
package ebpa_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_REQ = 3'b001,
        ST_WAITBB = 3'b010,
        ST_DATA = 3'b011,
        ST_DONE = 3'b100
    } ebpa_state_type;
    typedef enum logic [1:0] {
        PORT32 = 2'b00,
        PORT8 = 2'b01,
        PORT16 = 2'b10
    } ebpa_port_type;
    // pin levels, data bit 31 carries bus bit D0 (the msb)
    typedef struct packed {
        logic [31:0] data;
        logic [3:0] par;
        logic brN;
        logic bgN;
        logic bbN;
        logic taN;
        logic cr;
        logic kr;
        logic debug_freeze;
    } ebpa_pins_type;
    typedef struct packed {
        logic req;
        logic write;
        logic bankHit;
        logic [2:0] bank;
        logic [2:0] prio;
        ebpa_port_type size;
        logic [31:0] wdata;
    } ebpa_xfer_type;
    typedef struct packed {
        logic done;
        logic timeout;
        logic parErr;
        logic [31:0] rdata;
    } ebpa_resp_type;
endpackage

// File: hw/ebpa_sync.sv
// two-flop synchroniser for pin levels
`timescale 1ns/1ns
module ebpa_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] metaQ;
    // first stage feeds only the second; reset loads the idle levels of the pins
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            metaQ <= INIT;
            q <= INIT;
        end else begin
            metaQ <= d;
            q <= metaQ;
        end
    end
endmodule // ebpa_sync

// File: hw/ebpa_parity.sv
// per byte lane parity of a 32-bit word, lane 0 in the top byte
`timescale 1ns/1ns
module ebpa_parity (
    input wire logic [31:0] data,
    input wire logic even,
    output logic [3:0] par
);
    function automatic logic lanePar(input logic [7:0] b, input logic ev);
        lanePar = (^b) ^ ~ev;
    endfunction
    // lane i covers bus bits 8i..8i+7, i.e. vector bits 31-8i down to 24-8i
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            par[i] = lanePar(data[31-8*i -: 8], even);
        end
    end
endmodule // ebpa_parity

// File: hw/ebpa_arbiter.sv
// external bus pin logic: sized transfers, lane parity, arbitration, shared irq lines
//
// Notes on behaviour
// - transfers are sized to 8, 16 or 32 bits by the slave port width
// - bus bit D0 is the msb; it sits in vector bit 31
// - one parity bit per byte lane, lane 0 on D0-D7 through lane 3
// - parity enable per memory bank plus one enable for other slaves
// - parity only driven and checked on our own transfers
// - each lane parity pin may serve as an interrupt request input
// - ext_int_req3 is the and of lane 0 parity and cancel reservation
// - ext_int_req4 is the and of lane 1 parity and kill reservation
// - ext_int_req6 is the and of lane 3 parity and debug freeze
// - with the internal arbiter bus request is an input
// - with an external arbiter we drive bus request before each transfer
// - internal arbiter grants an external master that outranks our request
// - with an external arbiter bus grant is an input
// - the owner holds bus busy low while it owns the bus
// - we take bus busy only when granted and bus busy is free
// - bus monitor timeout pulses transfer error and ends the cycle
`timescale 1ns/1ns
`include "ebpa_consts.svh"
module ebpa_arbiter #(
    parameter int MON_CYCLES = `EBPA_MON_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire ebpa_pkg::ebpa_xfer_type xfer,
    output ebpa_pkg::ebpa_resp_type resp,
    output logic busOwned,
    input wire ebpa_pkg::ebpa_pins_type pinsIn,
    output logic [31:0] dataOut,
    output logic [31:0] dataOe,
    output logic [3:0] laneParityOut,
    output logic [3:0] laneParityOe,
    output logic busRequestNOut,
    output logic busRequestNOe,
    output logic busGrantNOut,
    output logic busGrantNOe,
    output logic busBusyNOut,
    output logic busBusyNOe,
    output logic transferErrorNOut,
    output logic transferErrorNOe,
    output logic extIntReq3N,
    output logic extIntReq4N,
    output logic extIntReq5N,
    output logic extIntReq6N
);
    localparam int MW = $clog2(MON_CYCLES + 1);
    localparam logic [MW-1:0] MON_LAST = MW'(MON_CYCLES - 1);

    ebpa_pkg::ebpa_pins_type pins;
    ebpa_pkg::ebpa_state_type state_q;
    logic [31:0] ctrl_q;
    logic [7:0] bankPar_q;
    logic [6:0] irqSel_q;
    logic parErr_q, timeout_q;
    logic [3:0] laneErr_q;
    logic [7:0] addr_q;
    logic wr_q, sel_q;
    logic grantExt_q, teaPulse_q;
    logic [MW-1:0] mon_q;
    logic [1:0] beatLeft_q;
    logic [31:0] shift_q, rd_q;
    logic write_q, parEn_q;
    ebpa_pkg::ebpa_port_type size_q;
    logic extArb, evenPar, wrEn, taSeen, lastBeat, monDone, parCheck;
    logic [3:0] genPar, rxPar, mask, mism;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [3:0] laneMask(input ebpa_pkg::ebpa_port_type s);
        unique case (s)
            ebpa_pkg::PORT8: laneMask = 4'h1;
            ebpa_pkg::PORT16: laneMask = 4'h3;
            default: laneMask = 4'hf;
        endcase
    endfunction
    function automatic logic [5:0] portBits(input ebpa_pkg::ebpa_port_type s);
        unique case (s)
            ebpa_pkg::PORT8: portBits = 6'h08;
            ebpa_pkg::PORT16: portBits = 6'h10;
            default: portBits = 6'h20;
        endcase
    endfunction

    // ----------------------------------------
    // pin synchronisers and parity units
    // ----------------------------------------
    ebpa_sync #(.W($bits(ebpa_pkg::ebpa_pins_type)), .INIT({32'h0, 4'hf, 7'h7f})) u_sync (
        .clk(clk),
        .resetn(resetn),
        .d(pinsIn),
        .q(pins) // strobes reset high, so no false grant or ack follows reset
    );
    ebpa_parity u_gen (
        .data(shift_q),
        .even(evenPar),
        .par(genPar)
    );
    ebpa_parity u_chk (
        .data(pins.data),
        .even(evenPar),
        .par(rxPar)
    );

    assign extArb = ctrl_q[`EBPA_CTRL_EXTARB];
    assign evenPar = ctrl_q[`EBPA_CTRL_EVENPAR];
    assign mask = laneMask(size_q);
    assign taSeen = (state_q == ebpa_pkg::ST_DATA) && !pins.taN;
    assign lastBeat = (beatLeft_q == 2'h0);
    assign monDone = (state_q == ebpa_pkg::ST_DATA) && pins.taN && (mon_q == MON_LAST);
    // only our own reads with parity enabled are checked; irq lanes carry no parity
    assign parCheck = taSeen && !write_q && parEn_q;
    assign mism = (rxPar ^ pins.par) & mask & ~irqSel_q[3:0];

    // ----------------------------------------
    // ahb-lite slave, zero wait states
    // ----------------------------------------
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wrEn = sel_q && wr_q;

    // address phase capture
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            sel_q <= 1'b0;
        end else if (hready) begin
            sel_q <= hsel && htrans[1];
            addr_q <= haddr[7:0];
            wr_q <= hwrite;
        end
    end

    // read data is registered at the address phase so it stands in the data phase
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                `EBPA_CTRL_OFS: hrdata <= ctrl_q;
                `EBPA_BANKPAR_OFS: hrdata <= {24'h000000, bankPar_q};
                `EBPA_IRQSEL_OFS: hrdata <= {25'h0000000, irqSel_q};
                `EBPA_STATUS_OFS: hrdata <= {21'h000000, state_q, laneErr_q, 1'b0,
                    timeout_q, parErr_q, busOwned};
                default: hrdata <= 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    // configuration registers; changing mode mid transfer is the user's hazard
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= `EBPA_CTRL_RESET;
            bankPar_q <= `EBPA_BANKPAR_RESET;
            irqSel_q <= `EBPA_IRQSEL_RESET;
        end else if (wrEn) begin
            if (addr_q == `EBPA_CTRL_OFS) ctrl_q <= {25'h0000000, hwdata[6:4], 1'b0, hwdata[2:0]};
            if (addr_q == `EBPA_BANKPAR_OFS) bankPar_q <= hwdata[7:0];
            if (addr_q == `EBPA_IRQSEL_OFS) irqSel_q <= hwdata[6:0];
        end
    end

    // sticky error flags, write one to clear; a new event wins over the clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            parErr_q <= 1'b0;
            timeout_q <= 1'b0;
            laneErr_q <= 4'h0;
        end else begin
            if (wrEn && addr_q == `EBPA_STATUS_OFS) begin
                parErr_q <= hwdata[`EBPA_ST_PARERR] ? 1'b0 : parErr_q;
                timeout_q <= hwdata[`EBPA_ST_TIMEOUT] ? 1'b0 : timeout_q;
                laneErr_q <= laneErr_q & ~hwdata[7:4];
            end
            if (parCheck && |mism) begin
                parErr_q <= 1'b1;
                laneErr_q <= (wrEn && addr_q == `EBPA_STATUS_OFS ?
                    laneErr_q & ~hwdata[7:4] : laneErr_q) | mism;
            end
            if (monDone) timeout_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // internal arbiter grant to an external master
    // ----------------------------------------
    // granted when its request outranks a pending request of ours, held while it asks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            grantExt_q <= 1'b0;
        end else if (extArb || pins.brN) begin
            grantExt_q <= 1'b0;
        end else if (state_q == ebpa_pkg::ST_IDLE || state_q == ebpa_pkg::ST_WAITBB) begin
            if (!xfer.req || ctrl_q[6:4] > xfer.prio) grantExt_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ebpa_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                ebpa_pkg::ST_IDLE:
                    if (xfer.req && !grantExt_q) begin
                        state_q <= extArb ? ebpa_pkg::ST_REQ : ebpa_pkg::ST_WAITBB;
                    end
                ebpa_pkg::ST_REQ:
                    if (!pins.bgN && pins.bbN) state_q <= ebpa_pkg::ST_DATA;
                ebpa_pkg::ST_WAITBB:
                    if (!grantExt_q && pins.bbN) state_q <= ebpa_pkg::ST_DATA;
                ebpa_pkg::ST_DATA:
                    if ((taSeen && lastBeat) || monDone) state_q <= ebpa_pkg::ST_DONE;
                ebpa_pkg::ST_DONE:
                    state_q <= ebpa_pkg::ST_IDLE;
            endcase
        end
    end

    // transfer attributes and data shifter; narrow ports take several beats
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            shift_q <= 32'h0000_0000;
            rd_q <= 32'h0000_0000;
            beatLeft_q <= 2'h0;
            size_q <= ebpa_pkg::PORT32;
            write_q <= 1'b0;
            parEn_q <= 1'b0;
        end else if (state_q == ebpa_pkg::ST_IDLE && xfer.req) begin
            shift_q <= xfer.wdata;
            size_q <= xfer.size;
            beatLeft_q <= xfer.size == ebpa_pkg::PORT8 ? 2'h3 :
                (xfer.size == ebpa_pkg::PORT16 ? 2'h1 : 2'h0);
            write_q <= xfer.write;
            parEn_q <= xfer.bankHit ? bankPar_q[xfer.bank] :
                ctrl_q[`EBPA_CTRL_OTHERPAR];
        end else if (taSeen) begin
            // earlier beats land in the more significant bits, D0 first
            shift_q <= shift_q << portBits(size_q);
            rd_q <= size_q == ebpa_pkg::PORT32 ? pins.data :
                (rd_q << portBits(size_q)) | (pins.data >> (6'h20 - portBits(size_q)));
            beatLeft_q <= beatLeft_q - 2'h1;
        end
    end

    // bus monitor counts each beat separately
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mon_q <= '0;
        end else if (state_q != ebpa_pkg::ST_DATA || taSeen) begin
            mon_q <= '0;
        end else if (mon_q != MON_LAST) begin
            mon_q <= mon_q + MW'(1);
        end
    end

    // one-cycle transfer error pulse on timeout
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) teaPulse_q <= 1'b0;
        else teaPulse_q <= monDone;
    end

    // answer to the internal requester
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            resp <= '0;
        end else begin
            resp.done <= (taSeen && lastBeat) || monDone;
            resp.timeout <= monDone;
            resp.parErr <= parCheck && |mism;
            resp.rdata <= (taSeen && lastBeat && !write_q) ? (size_q == ebpa_pkg::PORT32 ?
                pins.data : (rd_q << portBits(size_q)) |
                (pins.data >> (6'h20 - portBits(size_q)))) : resp.rdata;
        end
    end

    // shared interrupt lines, active low; an unselected pin leaves the and high
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            extIntReq3N <= 1'b1;
            extIntReq4N <= 1'b1;
            extIntReq5N <= 1'b1;
            extIntReq6N <= 1'b1;
        end else begin
            extIntReq3N <= (pins.par[0] | ~irqSel_q[0]) &
                (pins.cr | ~irqSel_q[`EBPA_IRQSEL_CR]);
            extIntReq4N <= (pins.par[1] | ~irqSel_q[1]) &
                (pins.kr | ~irqSel_q[`EBPA_IRQSEL_KR]);
            extIntReq5N <= pins.par[2] | ~irqSel_q[2];
            extIntReq6N <= (pins.par[3] | ~irqSel_q[3]) &
                (pins.debug_freeze | ~irqSel_q[`EBPA_IRQSEL_FRZ]);
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    assign busOwned = state_q == ebpa_pkg::ST_DATA;
    assign dataOut = shift_q;
    assign dataOe = busOwned && write_q ? {{8{mask[0]}}, {8{mask[1]}},
        {8{mask[2]}}, {8{mask[3]}}} : 32'h0000_0000;
    assign laneParityOut = genPar;
    // external masters' cycles never see our parity driven
    assign laneParityOe = (busOwned && write_q && parEn_q) ? mask & ~irqSel_q[3:0] : 4'h0;
    assign busRequestNOut = 1'b0;
    assign busRequestNOe = extArb && state_q == ebpa_pkg::ST_REQ;
    assign busGrantNOut = 1'b0;
    assign busGrantNOe = !extArb && grantExt_q;
    // busy is driven low while owned, then high one cycle before release
    assign busBusyNOut = !busOwned;
    assign busBusyNOe = busOwned || state_q == ebpa_pkg::ST_DONE;
    assign transferErrorNOut = 1'b0;
    assign transferErrorNOe = teaPulse_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    property p_takeBusy;
        @(posedge clk) disable iff (!resetn)
        $rose(busOwned) |-> $past(pins.bbN) && ($past(!pins.bgN) || !extArb);
    endproperty
    a_takeBusy: assert property (p_takeBusy) else $error("busy taken while bus not free");
    property p_holdBusy;
        @(posedge clk) disable iff (!resetn)
        busOwned |-> busBusyNOe && !busBusyNOut;
    endproperty
    a_holdBusy: assert property (p_holdBusy) else $error("busy not held while owner");
    property p_request;
        @(posedge clk) disable iff (!resetn)
        $rose(busOwned) && extArb |-> $past(busRequestNOe) && !busRequestNOe;
    endproperty
    a_request: assert property (p_request) else $error("no bus request before transfer");
    property p_brInput;
        @(posedge clk) disable iff (!resetn)
        !extArb |-> !busRequestNOe;
    endproperty
    a_brInput: assert property (p_brInput) else $error("request driven in internal mode");
    property p_bgInput;
        @(posedge clk) disable iff (!resetn)
        extArb |-> !busGrantNOe;
    endproperty
    a_bgInput: assert property (p_bgInput) else $error("grant driven in external mode");
    property p_grant;
        @(posedge clk) disable iff (!resetn)
        !extArb && !pins.brN && state_q == ebpa_pkg::ST_IDLE && !xfer.req
            && $stable(extArb) ##1 !pins.brN && !extArb |-> busGrantNOe && !busGrantNOut;
    endproperty
    a_grant: assert property (p_grant) else $error("external request not granted");
    property p_ext_int_req3;
        @(posedge clk) disable iff (!resetn)
        irqSel_q[0] && irqSel_q[`EBPA_IRQSEL_CR] && $stable(irqSel_q)
            |=> extIntReq3N == ($past(pins.par[0]) & $past(pins.cr));
    endproperty
    a_ext_int_req3: assert property (p_ext_int_req3) else $error("ext_int_req3 is not the and of its pins");
    property p_tea;
        @(posedge clk) disable iff (!resetn)
        monDone |=> transferErrorNOe && state_q == ebpa_pkg::ST_DONE ##1 !transferErrorNOe;
    endproperty
    a_tea: assert property (p_tea) else $error("timeout without transfer error pulse");
    property p_parOwn;
        @(posedge clk) disable iff (!resetn)
        !busOwned |-> laneParityOe == 4'h0 && dataOe == 32'h0000_0000;
    endproperty
    a_parOwn: assert property (p_parOwn) else $error("parity driven outside own cycle");
    property p_parErr;
        @(posedge clk) disable iff (!resetn)
        parCheck && |mism |=> parErr_q && resp.parErr && (laneErr_q & $past(mism)) == $past(mism);
    endproperty
    a_parErr: assert property (p_parErr) else $error("parity mismatch not flagged");
endmodule // ebpa_arbiter

// File: bench/ebpa_far_side.sv
// far side model: slave that answers beats, other master and outside arbiter pins
`timescale 1ns/1ns
module ebpa_far_side (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [31:0] dataOut,
    input wire logic [31:0] dataOe,
    input wire logic [3:0] laneParityOut,
    input wire logic [3:0] laneParityOe,
    input wire logic [2:0] nOut,
    input wire logic [2:0] nOe,
    input wire logic [31:0] rdWord,
    input wire logic [4:0] step,
    input wire logic [3:0] badLane,
    input wire logic noAck,
    input wire logic [1:0] extN,
    input wire logic [3:0] irqPar,
    input wire logic [2:0] shared,
    output ebpa_pkg::ebpa_pins_type pins
);
    logic [31:0] sh_q, last_q;
    logic [2:0] cnt_q, n;
    logic ta_q, rd;
    // released control lines go to pull-up or to the other master and arbiter
    assign n = (nOe & nOut) | (~nOe & {1'b1, extN});
    assign rd = !n[2] && dataOe == '0;
    // odd parity per byte lane, lane 0 on the top byte
    function automatic logic [3:0] par(input logic [31:0] d);
        for (int i = 0; i < 4; i++)
            par[i] = ~^d[31-8*i -: 8];
    endfunction
    // an undriven data bus shows a changing pattern so a stale value cannot pass
    always_comb begin
        pins = '0;
        pins.data = (dataOe & dataOut) | (~dataOe & (rd ? sh_q : ~last_q));
        pins.par = rd ? par(sh_q) ^ badLane : irqPar;
        pins.par = (laneParityOe & laneParityOut) | (~laneParityOe & pins.par);
        {pins.bbN, pins.bgN, pins.brN} = n;
        pins.taN = ta_q;
        {pins.debug_freeze, pins.kr, pins.cr} = shared;
    end
    // one ack every five busy cycles: slow enough for the two-flop synchronisers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {sh_q, last_q, cnt_q} <= '0;
            ta_q <= 1'b1;
        end else begin
            last_q <= pins.data;
            ta_q <= n[2] || noAck || cnt_q != 3'd3;
            cnt_q <= (n[2] || cnt_q == 3'd4) ? 3'd0 : cnt_q + 3'd1;
            sh_q <= n[2] ? rdWord : (ta_q ? sh_q : sh_q << step);
        end
    end
endmodule // ebpa_far_side

// File: bench/ext_bus_parity_arbitration_test.sv
// self-checking bench for the external bus pin logic
`timescale 1ns/1ns
`include "ebpa_consts.svh"
module ext_bus_parity_arbitration_test;
    logic clk = 1'b0;
    logic resetn, hsel, hwrite, hreadyout, hresp, busOwned, noAck, perr, teSeen, seenB;
    logic busRequestNOut, busRequestNOe, busGrantNOut, busGrantNOe, busBusyNOut, busBusyNOe;
    logic transferErrorNOut, transferErrorNOe, extIntReq3N, extIntReq4N, extIntReq5N, extIntReq6N;
    logic [1:0] htrans, extN;
    logic [2:0] hsize, shared;
    logic [3:0] badLane, irqPar, laneParityOut, laneParityOe, seenP;
    logic [4:0] step;
    logic [31:0] haddr, hwdata, hrdata, rdWord, dataOut, dataOe, r, seenD;
    int fail_count = 0;
    int checks = 0;
    ebpa_pkg::ebpa_xfer_type xfer;
    ebpa_pkg::ebpa_resp_type resp, got;
    ebpa_pkg::ebpa_pins_type pins;
    wire [3:0] irqN = {extIntReq6N, extIntReq5N, extIntReq4N, extIntReq3N};
    ebpa_arbiter #(.MON_CYCLES(16)) uut (
        .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hresp, .hrdata, .xfer, .resp, .busOwned, .pinsIn(pins), .dataOut,
        .dataOe, .laneParityOut, .laneParityOe, .busRequestNOut, .busRequestNOe,
        .busGrantNOut, .busGrantNOe, .busBusyNOut, .busBusyNOe, .transferErrorNOut,
        .transferErrorNOe, .extIntReq3N, .extIntReq4N, .extIntReq5N, .extIntReq6N
    );
    ebpa_far_side far (
        .clk, .resetn, .dataOut, .dataOe, .laneParityOut, .laneParityOe, .rdWord, .step,
        .nOut({busBusyNOut, busGrantNOut, busRequestNOut}), .badLane, .noAck, .extN,
        .nOe({busBusyNOe, busGrantNOe, busRequestNOe}), .irqPar, .shared, .pins
    );
    // 100 MHz clock
    always #5 clk = ~clk;
    // capture pin levels of our own data phase and short pulses
    always @(posedge clk) begin
        if (busOwned === 1'b1 && dataOe[31] === 1'b1) begin
            seenD <= dataOut;
            seenP <= laneParityOut | ~laneParityOe;
            seenB <= busBusyNOut | ~busBusyNOe;
        end
        if (resp.parErr === 1'b1) perr <= 1'b1;
        if (transferErrorNOe === 1'b1 && transferErrorNOut === 1'b0) teSeen <= 1'b1;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // bounded wait on transfer done or bus ready; a hang ends the run
    task automatic waitOn(input logic done);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((done ? resp.done : hreadyout) !== 1'b1 && n < 300);
        if (n >= 300) begin
            fail_count++;
            conclude();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        waitOn(1'b0);
        htrans <= 2'h0;
        hwdata <= d;
        waitOn(1'b0);
        r = hrdata;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, '0);
        chk(r, e);
        chk(hresp, 1'b0);
    endtask
    // req is dropped in the cycle after done so the transfer does not restart
    task automatic run(input logic w, input ebpa_pkg::ebpa_port_type sz);
        xfer.req <= 1'b1;
        xfer.write <= w;
        xfer.size <= sz;
        waitOn(1'b1);
        got = resp;
        xfer.req <= 1'b0;
        @(posedge clk); // pulse captures land before the caller compares
    endtask
    // ----
    // scenarios
    // ----
    task automatic regsT();
        rd(`EBPA_CTRL_OFS, `EBPA_CTRL_RESET);
        rd(`EBPA_IRQSEL_OFS, 32'h0);
        rd(8'h40, 32'h0);
        ahb(1'b1, `EBPA_CTRL_OFS, 32'h72);
        rd(`EBPA_CTRL_OFS, 32'h72);
    endtask
    task automatic wrT();
        xfer.wdata <= 32'h12345678;
        run(1'b1, ebpa_pkg::PORT32);
        chk(seenD, 32'h12345678);
        chk(seenP, {~^8'h78, ~^8'h56, ~^8'h34, ~^8'h12});
        chk(seenB, 1'b0);
        chk(got.timeout, 1'b0);
    endtask
    task automatic rdT();
        for (int i = 0; i < 3; i++) begin
            rdWord <= {8'ha5, 8'h3c, 8'h5a, 8'(i)};
            step <= 5'(8 << i);
            perr <= 1'b0;
            run(1'b0, ebpa_pkg::ebpa_port_type'((i + 1) % 3));
            chk(got.rdata, rdWord);
            chk(perr, 1'b0);
        end
    endtask
    // lane 2 corrupted: other-slave enable and disable, then bank 2 enable and disable
    task automatic parT();
        logic [7:0] bp[4] = '{8'h0, 8'h4, 8'h4, 8'hfb};
        badLane <= 4'h4;
        xfer.bank <= 3'd2;
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, `EBPA_CTRL_OFS, i ? 32'h70 : 32'h72);
            ahb(1'b1, `EBPA_BANKPAR_OFS, {24'h0, bp[i]});
            xfer.bankHit <= i[1];
            perr <= 1'b0;
            run(1'b0, ebpa_pkg::PORT32);
            chk(perr, 4'b0101 >> i & 1);
        end
        badLane <= 4'h0;
        rd(`EBPA_STATUS_OFS, 32'h42);
        ahb(1'b1, `EBPA_STATUS_OFS, 32'hf6);
        rd(`EBPA_STATUS_OFS, 32'h0);
    endtask
    task automatic toT();
        noAck <= 1'b1;
        teSeen <= 1'b0;
        run(1'b0, ebpa_pkg::PORT32);
        noAck <= 1'b0;
        chk(got.timeout, 1'b1);
        chk(teSeen, 1'b1);
        rd(`EBPA_STATUS_OFS, 32'h4);
    endtask
    // all parity pins as requests, 0, 1 and 3 shared with the three other pins
    task automatic irqT();
        int n;
        logic [3:0] e;
        ahb(1'b1, `EBPA_IRQSEL_OFS, 32'h7f);
        for (int i = 0; i < 3; i++) begin
            irqPar <= 4'(12'hb4f >> 4 * i);
            shared <= 3'(9'o277 >> 3 * i);
            e = 4'(12'h24f >> 4 * i);
            for (n = 0; n < 8 && irqN !== e; n++)
                @(posedge clk);
            chk(irqN, e);
        end
    endtask
    task automatic arbT();
        ahb(1'b1, `EBPA_CTRL_OFS, 32'h1);
        xfer.req <= 1'b1;
        xfer.write <= 1'b1;
        repeat (8) @(posedge clk);
        chk({busRequestNOe, busRequestNOut, busOwned}, 3'b100);
        extN <= 2'b01;
        run(1'b1, ebpa_pkg::PORT32);
        extN <= 2'b11;
        repeat (3) @(posedge clk);
        chk(busRequestNOe, 1'b0);
    endtask
    task automatic grT();
        ahb(1'b1, `EBPA_CTRL_OFS, 32'h70);
        extN <= 2'b10;
        repeat (6) @(posedge clk);
        chk({busGrantNOe, busGrantNOut}, 2'b10);
        extN <= 2'b11;
    endtask
    // reset for two cycles, then every scenario in turn
    initial begin
        {resetn, hsel, hwrite, noAck, perr, teSeen, htrans, haddr, hwdata} = '0;
        {xfer, rdWord, step, badLane} = '0;
        {extN, irqPar, shared} = '1;
        hsize = 3'h2;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        regsT();
        wrT();
        rdT();
        parT();
        toT();
        irqT();
        arbT();
        grT();
        conclude();
    end
endmodule // ext_bus_parity_arbitration_test
